// file: design/dmfc_pkg.sv
package dmfc_pkg;
  // ----------------------------------------------------------------
  // parameter indexes
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SAMP   = 16'h1110;
  localparam logic [15:0] IDX_TOL1   = 16'h1113;
  localparam logic [15:0] IDX_TOL2   = 16'h1114;
  localparam logic [15:0] IDX_AVG    = 16'h1115;
  localparam logic [15:0] IDX_MED    = 16'h1116;
  localparam logic [15:0] IDX_POL    = 16'h1117;
  localparam logic [15:0] IDX_ZERO   = 16'h1118;
  localparam logic [15:0] IDX_HOLD   = 16'h1119;
  localparam logic [15:0] IDX_CLAMP  = 16'h111a;
  localparam logic [15:0] IDX_EMODE  = 16'h111b;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SAMP   = 16'h00c8;
  localparam logic [15:0] RST_AVG    = 16'h0080;
  localparam logic [15:0] RST_MED    = 16'h0003;
  localparam logic [7:0]  RST_POL    = 8'h00;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RST_HOLD   = 32'h0000_0001;
  localparam logic [31:0] RST_CLAMP  = 32'h0beb_c200;
  localparam logic [7:0]  RST_EMODE  = 8'h00;

  // ----------------------------------------------------------------
  // codes and ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] SP_AUTO    = 16'h0000;
  localparam logic [15:0] SP_133     = 16'h0085;
  localparam logic [15:0] SP_200     = 16'h00c8;
  localparam logic [15:0] SP_300     = 16'h012c;
  localparam logic [15:0] SP_500     = 16'h01f4;
  localparam logic [15:0] SP_1000    = 16'h03e8;
  localparam logic [15:0] SP_2000    = 16'h07d0;
  localparam logic [15:0] SP_5000    = 16'h1388;
  localparam logic [15:0] AVG_OFF    = 16'h0001;
  localparam logic [31:0] HOLD_MIN   = 32'h0000_0001;
  localparam logic [31:0] HOLD_MAX   = 32'h0001_86a0;
  localparam logic signed [31:0] CLAMP_MAX = 32'sh0beb_c200;
  localparam logic [7:0]  EM_CLAMP   = 8'h00;
  localparam logic [7:0]  EM_HOLD    = 8'h01;
  localparam logic [7:0]  EM_TIMED   = 8'h02;

  // ----------------------------------------------------------------
  // times in ns
  // ----------------------------------------------------------------
  localparam longint SP_133_NS  = 133300;
  localparam longint SP_200_NS  = 200000;
  localparam longint SP_300_NS  = 300000;
  localparam longint SP_500_NS  = 500000;
  localparam longint SP_1000_NS = 1000000;
  localparam longint SP_2000_NS = 2000000;
  localparam longint SP_5000_NS = 5000000;
  localparam longint MS_NS      = 1000000;

  // result word carried through the output buffer
  typedef struct packed {
    logic               fail;
    logic signed [31:0] val;
  } dmfc_res_s;
endpackage

// file: design/dmfc_buf.sv
`timescale 1ns/1ns
// small fifo with valid/ready on both sides
module dmfc_buf #(
  parameter int W     = 33,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  assign in_ready_out  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out  = mem_ff[rp_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // wrap pointers at depth, which need not be a power of two
  always_comb begin
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wp = (wp_ff == AW'(DEPTH-1)) ? '0 : AW'(wp_ff + 1'b1);
    end
    if (pop) begin
      nxt_rp = (rp_ff == AW'(DEPTH-1)) ? '0 : AW'(rp_ff + 1'b1);
    end
    if (push && !pop) begin
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset; empty flag hides stale words
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_in;
    end
  end
endmodule

// file: design/dmfc_median.sv
`timescale 1ns/1ns
// median of the newest win samples; win 0 means bypass
module dmfc_median #(
  parameter int DEPTH = 31
) (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               clr_in,
  input  wire logic               push_in,
  input  wire logic signed [31:0] sample_in,
  input  wire logic [4:0]         win_in,
  output logic signed [31:0]      med_out
);
  logic signed [31:0] hist_ff [DEPTH];
  logic [5:0]         fill_ff, nxt_fill;
  logic [5:0]         lt [DEPTH];
  logic [5:0]         le [DEPTH];
  logic [5:0]         win, k;

  assign win = {1'b0, win_in};
  assign k   = 6'(win >> 1);

  // ----------------------------------------------------------------
  // rank of each entry inside the window
  // ----------------------------------------------------------------
  // brute force ranking: wide but single cycle, no sorting network
  for (genvar i = 0; i < DEPTH; i++) begin : g_rank
    always_comb begin
      lt[i] = '0;
      le[i] = '0;
      for (int j = 0; j < DEPTH; j++) begin
        if (6'(j) < win) begin
          lt[i] = 6'(lt[i] + (hist_ff[j] <  hist_ff[i]));
          le[i] = 6'(le[i] + (hist_ff[j] <= hist_ff[i]));
        end
      end
    end
  end

  // middle entry wins; until the window fills, pass the newest sample
  always_comb begin
    med_out = hist_ff[0];
    if (fill_ff >= win && win != '0) begin
      for (int i = DEPTH - 1; i >= 0; i--) begin
        if (6'(i) < win && lt[i] <= k && le[i] > k) begin
          med_out = hist_ff[i];
        end
      end
    end
  end

  always_comb begin
    nxt_fill = fill_ff;
    if (clr_in) begin
      nxt_fill = '0;
    end else if (push_in && fill_ff != 6'(DEPTH)) begin
      nxt_fill = 6'(fill_ff + 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fill_ff <= '0;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  // newest sample at entry 0
  always_ff @(posedge clk_in) begin
    if (push_in) begin
      hist_ff[0] <= sample_in;
      for (int i = 1; i < DEPTH; i++) begin
        hist_ff[i] <= hist_ff[i-1];
      end
    end
  end
endmodule

// file: design/dmfc_top.sv
`timescale 1ns/1ns
module dmfc_top
  import dmfc_pkg::*;
#(
  parameter int          CLK_KHZ  = 25000,
  parameter logic [31:0] TOL1_RST = 32'h000f_4240,
  parameter logic [31:0] TOL2_RST = 32'h000f_4240
) (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               par_req_in,
  input  wire logic               par_we_in,
  input  wire logic [15:0]        par_idx_in,
  input  wire logic [31:0]        par_wdata_in,
  output logic                    par_ack_out,
  output logic                    par_nak_out,
  output logic [31:0]             par_rdata_out,
  input  wire logic               zero_set_in,
  input  wire logic               zero_clr_in,
  output logic                    sample_tick_out,
  input  wire logic               sample_valid_in,
  input  wire logic               sample_fail_in,
  input  wire logic signed [31:0] sample_in,
  output logic                    sample_ready_out,
  output logic                    res_valid_out,
  input  wire logic               res_ready_in,
  output dmfc_pkg::dmfc_res_s     res_out,
  output logic                    first_switch_output_out,
  output logic                    second_switch_output_out
);
  import dmfc_pkg::*;

  localparam int AVG_MAX = 512;
  localparam longint MS_CYC = MS_NS * CLK_KHZ / 64'd1000000;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] period_cyc(input logic [15:0] c);
    longint ns;
    case (c)
      SP_133:  ns = SP_133_NS;
      SP_300:  ns = SP_300_NS;
      SP_500:  ns = SP_500_NS;
      SP_1000: ns = SP_1000_NS;
      SP_2000: ns = SP_2000_NS;
      SP_5000: ns = SP_5000_NS;
      default: ns = SP_200_NS;                    // auto runs at 200 us
    endcase
    return 32'(ns * CLK_KHZ / 64'd1000000);
  endfunction

  function automatic logic [3:0] avg_shift(input logic [15:0] c);
    avg_shift = '0;
    for (int b = 2; b < 10; b++) begin
      if (c == (16'h0001 << b)) begin
        avg_shift = 4'(b);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // parameter set
  // ----------------------------------------------------------------
  logic [15:0] samp_ff, avg_ff, med_ff, nxt_samp, nxt_avg, nxt_med;
  logic [7:0]  pol_ff, emode_ff, nxt_pol, nxt_emode;
  logic [31:0] tol1_ff, tol2_ff, hold_ff, nxt_tol1, nxt_tol2, nxt_hold;
  logic signed [31:0] zero_ff, clamp_ff, nxt_zero, nxt_clamp;
  logic        ack_ff, nak_ff, nxt_ack, nxt_nak, cfg_ff, nxt_cfg;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        hit, ok;
  logic signed [31:0] wd, last_pol_ff;

  assign wd = par_wdata_in;

  // one access per request; reply flags come one cycle later
  always_comb begin
    nxt_samp = samp_ff;   nxt_avg = avg_ff;     nxt_med = med_ff;
    nxt_pol = pol_ff;     nxt_emode = emode_ff; nxt_tol1 = tol1_ff;
    nxt_tol2 = tol2_ff;   nxt_hold = hold_ff;   nxt_zero = zero_ff;
    nxt_clamp = clamp_ff; nxt_rdata = rdata_ff; nxt_cfg = 1'b0;
    nxt_ack = 1'b0;
    nxt_nak = 1'b0;
    hit = 1'b1;
    ok = 1'b1;
    case (par_idx_in)
      IDX_SAMP: begin
        nxt_rdata = {16'h0000, samp_ff};
        ok = (wd[31:16] == '0) && (wd[15:0] inside {SP_AUTO, SP_133,
             SP_200, SP_300, SP_500, SP_1000, SP_2000, SP_5000});
        if (par_we_in && ok) nxt_samp = wd[15:0];
      end
      IDX_TOL1: begin
        nxt_rdata = tol1_ff;
        if (par_we_in) nxt_tol1 = wd;
      end
      IDX_TOL2: begin
        nxt_rdata = tol2_ff;
        if (par_we_in) nxt_tol2 = wd;
      end
      IDX_AVG: begin
        nxt_rdata = {16'h0000, avg_ff};
        ok = (wd[31:16] == '0) &&
             (wd[15:0] == AVG_OFF || avg_shift(wd[15:0]) != '0);
        if (par_we_in && ok) nxt_avg = wd[15:0];
      end
      IDX_MED: begin
        nxt_rdata = {16'h0000, med_ff};
        ok = (wd[31:16] == '0) &&
             (wd[15:0] inside {16'h0000, 16'h0003, 16'h0007, 16'h000f,
              16'h001f});
        if (par_we_in && ok) nxt_med = wd[15:0];
      end
      IDX_POL: begin
        nxt_rdata = {24'h000000, pol_ff};
        ok = (wd[31:1] == '0);
        if (par_we_in && ok) nxt_pol = wd[7:0];
      end
      IDX_ZERO: begin
        nxt_rdata = zero_ff;
        if (par_we_in) nxt_zero = wd;
      end
      IDX_HOLD: begin
        nxt_rdata = hold_ff;
        ok = (wd >= HOLD_MIN) && (wd <= HOLD_MAX);      // unsigned compare
        if (par_we_in && ok) nxt_hold = wd;
      end
      IDX_CLAMP: begin
        nxt_rdata = clamp_ff;
        ok = (wd >= -CLAMP_MAX) && (wd <= CLAMP_MAX);
        if (par_we_in && ok) nxt_clamp = wd;
      end
      IDX_EMODE: begin
        nxt_rdata = {24'h000000, emode_ff};
        ok = (wd <= 32'(EM_TIMED));
        if (par_we_in && ok) nxt_emode = wd[7:0];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (par_req_in) begin
      nxt_ack = hit && (ok || !par_we_in);
      nxt_nak = !nxt_ack;
      nxt_cfg = par_we_in && nxt_ack &&
                (par_idx_in == IDX_AVG || par_idx_in == IDX_MED);
    end else begin
      nxt_rdata = rdata_ff;
    end
    // commands come after a register write; clear beats set
    if (zero_set_in) nxt_zero = last_pol_ff;
    if (zero_clr_in) nxt_zero = '0;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      samp_ff <= RST_SAMP;     avg_ff <= RST_AVG;     med_ff <= RST_MED;
      pol_ff <= RST_POL;       emode_ff <= RST_EMODE; tol1_ff <= TOL1_RST;
      tol2_ff <= TOL2_RST;     hold_ff <= RST_HOLD;   zero_ff <= RST_ZERO;
      clamp_ff <= RST_CLAMP;   rdata_ff <= '0;        cfg_ff <= 1'b0;
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
    end else begin
      samp_ff <= nxt_samp;     avg_ff <= nxt_avg;     med_ff <= nxt_med;
      pol_ff <= nxt_pol;       emode_ff <= nxt_emode; tol1_ff <= nxt_tol1;
      tol2_ff <= nxt_tol2;     hold_ff <= nxt_hold;   zero_ff <= nxt_zero;
      clamp_ff <= nxt_clamp;   rdata_ff <= nxt_rdata; cfg_ff <= nxt_cfg;
      ack_ff <= nxt_ack;
      nak_ff <= nxt_nak;
    end
  end

  assign par_ack_out   = ack_ff;
  assign par_nak_out   = nak_ff;
  assign par_rdata_out = rdata_ff;

  // ----------------------------------------------------------------
  // sampling tick
  // ----------------------------------------------------------------
  logic [31:0] tcnt_ff, nxt_tcnt;
  logic        tick_ff, nxt_tick;

  // a new period takes effect at the next wrap, not mid-period
  always_comb begin
    nxt_tick = (tcnt_ff == '0);
    nxt_tcnt = (tcnt_ff == '0) ? 32'(period_cyc(samp_ff) - 1'b1)
                               : 32'(tcnt_ff - 1'b1);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tcnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tcnt_ff <= nxt_tcnt;
      tick_ff <= nxt_tick;
    end
  end

  assign sample_tick_out = tick_ff;

  // ----------------------------------------------------------------
  // filter pipeline
  // ----------------------------------------------------------------
  logic               buf_rdy, accept, s1_ff, nxt_s1, s1f_ff, nxt_s1f;
  logic               r_ff, nxt_r, rf_ff, nxt_rf;
  logic signed [31:0] s1v_ff, nxt_s1v, med_val, x, rv_ff, nxt_rv;
  logic signed [31:0] hist_ff [AVG_MAX];
  logic signed [41:0] sum_ff, nxt_sum, old;
  logic [8:0]         wp_ff, nxt_wp;
  logic [9:0]         fill_ff, nxt_fill, len;
  logic [3:0]         sh;

  // one sample in flight at a time; the buffer stall reaches the source
  assign sample_ready_out = buf_rdy && !s1_ff && !r_ff;
  assign accept = sample_valid_in && sample_ready_out;

  dmfc_median u_med (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clr_in     (cfg_ff),
    .push_in    (accept && !sample_fail_in),
    .sample_in  (sample_in),
    .win_in     (med_ff[4:0]),
    .med_out    (med_val)
  );

  assign sh  = avg_shift(avg_ff);
  assign len = 10'h001 << sh;
  assign x   = (med_ff == '0) ? s1v_ff : med_val;

  // running sum over the window; mean only once the window is full
  always_comb begin
    nxt_s1 = accept;
    nxt_s1f = accept ? sample_fail_in : s1f_ff;
    nxt_s1v = accept ? sample_in : s1v_ff;
    nxt_r = s1_ff;
    nxt_rf = s1_ff ? s1f_ff : rf_ff;
    nxt_rv = rv_ff;
    nxt_sum = sum_ff;
    nxt_wp = wp_ff;
    nxt_fill = fill_ff;
    old = (fill_ff == len) ? 42'(hist_ff[9'(10'(wp_ff) - len)]) : '0;
    if (cfg_ff) begin
      nxt_sum = '0;
      nxt_fill = '0;
    end else if (s1_ff && !s1f_ff) begin
      nxt_sum = 42'(sum_ff + 42'(x) - old);
      nxt_wp = 9'(wp_ff + 1'b1);
      nxt_fill = (fill_ff == len) ? fill_ff : 10'(fill_ff + 1'b1);
      nxt_rv = (nxt_fill == len) ? 32'(nxt_sum >>> sh) : x;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_ff <= 1'b0;  s1f_ff <= 1'b0;  s1v_ff <= '0;
      r_ff <= 1'b0;   rf_ff <= 1'b0;   rv_ff <= '0;
      sum_ff <= '0;   wp_ff <= '0;     fill_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;  s1f_ff <= nxt_s1f;  s1v_ff <= nxt_s1v;
      r_ff <= nxt_r;    rf_ff <= nxt_rf;    rv_ff <= nxt_rv;
      sum_ff <= nxt_sum; wp_ff <= nxt_wp;  fill_ff <= nxt_fill;
    end
  end

  // sample storage needs no reset; the fill count guards it
  always_ff @(posedge clk_in) begin
    if (s1_ff && !s1f_ff) begin
      hist_ff[wp_ff] <= x;
    end
  end

  // ----------------------------------------------------------------
  // result stage
  // ----------------------------------------------------------------
  logic signed [31:0] pol_v, cor_v, good_ff, nxt_good, nxt_lpol;
  logic [31:0]        cyc_ff, nxt_cyc, ms_ff, nxt_ms, mag;
  logic               fa_ff, nxt_fa, sw1_ff, sw2_ff, nxt_sw1, nxt_sw2;
  dmfc_res_s          res_w;

  assign pol_v = (pol_ff == 8'h01) ? -rv_ff : rv_ff;
  assign cor_v = 32'(pol_v - zero_ff);
  assign mag   = cor_v[31] ? 32'(-cor_v) : cor_v;

  // failure substitute picked by error mode
  always_comb begin
    res_w.fail = rf_ff;
    res_w.val  = cor_v;
    if (rf_ff) begin
      case (emode_ff)
        EM_HOLD:  res_w.val = good_ff;
        EM_TIMED: res_w.val = (ms_ff >= hold_ff) ? clamp_ff
                                                 : good_ff;
        default:  res_w.val = clamp_ff;
      endcase
    end
  end

  // hold timer counts whole ms from the first failed result
  always_comb begin
    nxt_good = good_ff;
    nxt_lpol = last_pol_ff;
    nxt_fa = fa_ff;
    nxt_cyc = cyc_ff;
    nxt_ms = ms_ff;
    nxt_sw1 = sw1_ff;
    nxt_sw2 = sw2_ff;
    if (fa_ff) begin
      nxt_cyc = (cyc_ff == 32'(MS_CYC - 1)) ? '0 : 32'(cyc_ff + 1'b1);
      if (cyc_ff == 32'(MS_CYC - 1) && ms_ff != '1) begin
        nxt_ms = 32'(ms_ff + 1'b1);
      end
    end
    if (r_ff) begin
      nxt_sw1 = !rf_ff && (mag <= tol1_ff);
      nxt_sw2 = !rf_ff && (mag <= tol2_ff);
      if (rf_ff) begin
        nxt_fa = 1'b1;
      end else begin
        nxt_fa = 1'b0;
        nxt_cyc = '0;
        nxt_ms = '0;
        nxt_good = cor_v;
        nxt_lpol = pol_v;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      good_ff <= '0;  last_pol_ff <= '0;  fa_ff <= 1'b0;
      cyc_ff <= '0;   ms_ff <= '0;
      sw1_ff <= 1'b0;
      sw2_ff <= 1'b0;
    end else begin
      good_ff <= nxt_good;  last_pol_ff <= nxt_lpol;  fa_ff <= nxt_fa;
      cyc_ff <= nxt_cyc;    ms_ff <= nxt_ms;
      sw1_ff <= nxt_sw1;
      sw2_ff <= nxt_sw2;
    end
  end

  assign first_switch_output_out  = sw1_ff;
  assign second_switch_output_out = sw2_ff;

  // push cannot be refused: space was checked when the sample was taken
  dmfc_buf #(.W($bits(dmfc_res_s)), .DEPTH(2)) u_buf (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (r_ff),
    .in_ready_out  (buf_rdy),
    .in_data_in    (res_w),
    .out_valid_out (res_valid_out),
    .out_ready_in  (res_ready_in),
    .out_data_out  (res_out)
  );
endmodule

// file: testbench/dmfc_top_asserts.sv
`timescale 1ns/1ns
// --------------------
// port checks for the filter block
// --------------------
module dmfc_top_asserts
  import dmfc_pkg::*;
(
  input wire logic                clk_in,
  input wire logic                sys_rst_in,
  input wire logic                par_req_in,
  input wire logic                par_ack_out,
  input wire logic                par_nak_out,
  input wire logic [31:0]         par_rdata_out,
  input wire logic                sample_tick_out,
  input wire logic                sample_valid_in,
  input wire logic                sample_ready_out,
  input wire logic                res_valid_out,
  input wire logic                res_ready_in,
  input wire dmfc_pkg::dmfc_res_s res_out,
  input wire logic                first_switch_output_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // handshake and stream relations; all one domain
  ans_one_a: assert property (
    par_req_in |=> par_ack_out ^ par_nak_out) else $error("no single answer");
  quiet_port_a: assert property (
    !par_req_in |=> !par_ack_out && !par_nak_out) else $error("stray answer");
  rdata_hold_a: assert property (
    par_ack_out && !par_req_in |=> $stable(par_rdata_out)) else $error("rdata");
  take_gap_a: assert property (
    sample_valid_in && sample_ready_out |=> !sample_ready_out [*2])
    else $error("ready back too soon");
  res_due_a: assert property (
    sample_valid_in && sample_ready_out |-> ##[2:4] res_valid_out)
    else $error("result late");
  res_hold_a: assert property (
    res_valid_out && !res_ready_in |=> res_valid_out && $stable(res_out))
    else $error("result not held");
  tick_pulse_a: assert property (
    sample_tick_out |=> !sample_tick_out) else $error("tick too long");
  fail_switch_a: assert property (
    $rose(res_valid_out) && res_out.fail |-> !first_switch_output_out)
    else $error("switch on during failure");
  cover property (par_nak_out);
  cover property ($rose(res_valid_out) && res_out.fail);
  cover property (sample_valid_in && !sample_ready_out && res_valid_out);
endmodule

// file: testbench/dmfc_src.sv
`timescale 1ns/1ns
// --------------------
// sample source feeding the stream input
// --------------------
module dmfc_src (
  input  wire logic          clk_in,
  input  wire logic          ready_in,
  output logic               valid_out,
  output logic               fail_out,
  output logic signed [31:0] val_out
);
  initial {valid_out, fail_out, val_out} = '0;
  // offer until a ready edge takes it; afterwards scramble the bus
  task automatic send(input logic signed [31:0] v, input logic f);
    @(negedge clk_in);
    valid_out = 1'b1;
    fail_out  = f;
    val_out   = v;
    #1;
    while (ready_in !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    valid_out = 1'b0;
    val_out   = ~v; // stale word must never pass for a sample
  endtask
endmodule

// file: testbench/tb_dmfc_top.sv
`timescale 1ns/1ns
// --------------------
// bench for the filter block
// --------------------
module tb_dmfc_top;
  import dmfc_pkg::*;
  logic               clk_in, sys_rst_in, par_req_in, par_we_in;
  logic [15:0]        par_idx_in;
  logic [31:0]        par_wdata_in, par_rdata_out, n;
  logic               par_ack_out, par_nak_out, zero_set_in, zero_clr_in;
  logic               sample_tick_out, sample_valid_in, sample_fail_in;
  logic signed [31:0] sample_in;
  logic               sample_ready_out, res_valid_out, res_ready_in;
  logic               first_switch_output_out, second_switch_output_out;
  dmfc_res_s          res_out;
  int                 err_total, cmp_count, cyc;
  logic [15:0]        ix[10] = '{IDX_SAMP, IDX_TOL1, IDX_TOL2, IDX_AVG,
    IDX_MED, IDX_POL, IDX_ZERO, IDX_HOLD, IDX_CLAMP, IDX_EMODE};
  logic [31:0]        rv[10] = '{32'hc8, 32'hf4240, 32'hf4240, 32'h80,
    32'h3, 32'h0, 32'h0, 32'h1, 32'hbebc200, 32'h0};
  logic [15:0]        sp[8] = '{SP_AUTO, SP_133, SP_200, SP_500, SP_1000,
    SP_2000, SP_5000, SP_300};
  // 100 kHz makes 1 ms 100 cycles and 300 us 30 cycles
  dmfc_top #(.CLK_KHZ(100)) i_dut (.*);
  dmfc_src i_src (.clk_in(clk_in), .ready_in(sample_ready_out),
    .valid_out(sample_valid_in), .fail_out(sample_fail_in),
    .val_out(sample_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // one request, answer looked at in the cycle it stands
  task automatic acc(input logic w, input logic [15:0] i,
                     input logic [31:0] d, input logic nk);
    @(negedge clk_in);
    {par_req_in, par_we_in, par_idx_in, par_wdata_in} = {1'b1, w, i, d};
    @(negedge clk_in);
    par_req_in = 1'b0;
    chk("ack", 32'(!nk), 32'(par_ack_out));
    chk("nak", 32'(nk), 32'(par_nak_out));
    if (!w && !nk) chk("rdata", d, par_rdata_out);
  endtask
  task automatic wrd(input logic [15:0] i, input logic [31:0] d);
    acc(1'b1, i, d, 1'b0);
    acc(1'b0, i, d, 1'b0);
  endtask
  task automatic bad(input logic [15:0] i, input logic [31:0] d, b);
    wrd(i, d);
    acc(1'b1, i, b, 1'b1);
    acc(1'b0, i, d, 1'b0);
  endtask
  task automatic pull(input dmfc_res_s e);
    // let an edge pass so res_ready_in is never set twice in one step
    @(negedge clk_in);
    while (res_valid_out !== 1'b1) @(negedge clk_in);
    chk("res_val", e.val, res_out.val);
    chk("res_fail", 32'(e.fail), 32'(res_out.fail));
    res_ready_in = 1'b1;
    @(negedge clk_in);
    res_ready_in = 1'b0;
  endtask
  task automatic one(input logic signed [31:0] v, input logic f,
                     input dmfc_res_s e);
    i_src.send(v, f);
    pull(e);
  endtask
  task automatic cmd(input logic c);
    @(negedge clk_in);
    {zero_set_in, zero_clr_in} = {!c, c};
    @(negedge clk_in);
    {zero_set_in, zero_clr_in} = 2'b00;
  endtask
  initial begin
    sys_rst_in = 1'b1;
    {par_req_in, par_we_in, zero_set_in, zero_clr_in, res_ready_in} = '0;
    {par_idx_in, par_wdata_in} = '0;
    repeat (20) @(negedge clk_in);
    sys_rst_in = 1'b0;
    foreach (ix[k]) acc(1'b0, ix[k], rv[k], 1'b0);
    $display("test defaults done");
    foreach (sp[k]) wrd(IDX_SAMP, 32'(sp[k]));
    for (int k = 2; k < 10; k++) wrd(IDX_AVG, 32'h1 << k);
    for (int k = 2; k < 6; k++) wrd(IDX_MED, (32'h1 << k) - 1);
    acc(1'b0, 16'h1112, 32'h0, 1'b1);
    bad(IDX_SAMP, 32'(SP_300), 32'h86);
    bad(IDX_AVG, 32'(AVG_OFF), 32'h2);
    bad(IDX_MED, 32'h0, 32'h4);
    bad(IDX_POL, 32'h1, 32'h101);
    bad(IDX_HOLD, HOLD_MAX, HOLD_MAX + 1);
    bad(IDX_HOLD, HOLD_MIN, 32'h0);
    bad(IDX_CLAMP, -CLAMP_MAX, CLAMP_MAX + 1);
    bad(IDX_EMODE, 32'(EM_TIMED), 32'h3);
    $display("test codes done");
    while (sample_tick_out !== 1'b1) @(negedge clk_in);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (sample_tick_out !== 1'b1 && n < 1000);
    chk("tick_period", 32'd30, n);
    wrd(IDX_POL, 32'h0);
    wrd(IDX_EMODE, 32'(EM_CLAMP));
    wrd(IDX_TOL2, 32'h0);
    one(1000, 1'b0, {1'b0, 32'sd1000});
    chk("switches", 32'h2, 32'({first_switch_output_out,
      second_switch_output_out}));
    wrd(IDX_POL, 32'h1);
    one(1000, 1'b0, {1'b0, -32'sd1000});
    cmd(1'b0);
    one(1000, 1'b0, {1'b0, 32'sd0});
    cmd(1'b1);
    one(1000, 1'b0, {1'b0, -32'sd1000});
    one(5, 1'b1, {1'b1, -CLAMP_MAX});
    wrd(IDX_EMODE, 32'(EM_HOLD));
    one(5, 1'b1, {1'b1, -32'sd1000});
    wrd(IDX_EMODE, 32'(EM_TIMED));
    one(5, 1'b1, {1'b1, -32'sd1000});
    repeat (150) @(negedge clk_in);
    one(5, 1'b1, {1'b1, -CLAMP_MAX});
    $display("test zero and failure done");
    wrd(IDX_POL, 32'h0);
    wrd(IDX_AVG, 32'h4);
    for (int k = 1; k < 5; k++)
      one(10 * k, 1'b0, {1'b0, (k < 4) ? 32'(10 * k) : 32'sd25});
    wrd(IDX_AVG, 32'(AVG_OFF));
    wrd(IDX_MED, 32'h3);
    one(50, 1'b0, {1'b0, 32'sd50});
    one(5, 1'b0, {1'b0, 32'sd5});
    one(100, 1'b0, {1'b0, 32'sd50});
    wrd(IDX_MED, 32'h0);
    i_src.send(1, 1'b0);
    i_src.send(2, 1'b0);
    repeat (4) @(negedge clk_in);
    chk("ready_full", 32'h0, 32'(sample_ready_out));
    pull({1'b0, 32'sd1});
    pull({1'b0, 32'sd2});
    $display("test filters done");
    finish_test();
  end
endmodule
bind dmfc_top dmfc_top_asserts i_chk (.*);
